// ---- inc/sdfc_consts.svh ----
// offsets, field positions and port widths of the supply/debug/fail-safe control block
`ifndef SDFC_CONSTS_SVH
`define SDFC_CONSTS_SVH
`define SDFC_ADDR_W        4
`define SDFC_DATA_W        8
`define SDFC_OFF_SUPPLY    4'h0
`define SDFC_OFF_UV        4'h1
`define SDFC_OFF_IO        4'h2
`define SDFC_OFF_MUX       4'h3
`define SDFC_OFF_DEBUG     4'h4
`define SDFC_OFF_SAFE      4'h5
`define SDFC_OFF_STATUS    4'h6
// supply register fields
`define SDFC_BUS_EN_BIT    0
`define SDFC_AUX_EN_BIT    1
`define SDFC_AUX_3V3_BIT   2
`define SDFC_AUX_INT_BIT   3
// undervoltage register fields
`define SDFC_UV_INT_BIT    0
`define SDFC_UV_LOWER_BIT  1
// mux register fields
`define SDFC_MUX_LOAD_BIT  3
// debug register fields
`define SDFC_DBG_EXIT_BIT  0
// safe register fields
`define SDFC_SAFE_OVR_BIT  2
// status register fields
`define SDFC_ST_DBG_BIT    0
`define SDFC_ST_AUX_UV_BIT 1
`define SDFC_ST_AUX_OC_BIT 2
`define SDFC_ST_BUS_BIT    3
`define SDFC_ST_AUX_BIT    4
`define SDFC_ST_FAULT_BIT  5
`define SDFC_ZERO8         8'h00
`endif

// ---- inc/sdfc_pkg.sv ----
// types of the supply/debug/fail-safe control block
package sdfc_pkg;
  typedef enum logic [1:0] {
    IO_INPUT,
    IO_HIGH_SIDE,
    IO_LOW_SIDE,
    IO_HIGH_Z
  } sdfc_io_mode_t;

  typedef enum logic [2:0] {
    MUX_MAIN_SUPPLY,
    MUX_BATTERY_SENSE,
    MUX_IO0,
    MUX_IO1,
    MUX_REFERENCE,
    MUX_DIE_TEMP,
    MUX_REG_CURRENT
  } sdfc_mux_src_t;

  typedef enum {
    ST_INIT_RESET,
    ST_RUN
  } sdfc_phase_t;

  typedef struct packed {
    sdfc_phase_t      phase;
    logic             bus_en;
    logic             aux_en;
    logic             aux_3v3;
    logic             aux_int_en;
    logic             uv_int_sel;
    logic             uv_lower_sel;
    logic [7:0]       io_mode;
    sdfc_mux_src_t    mux_src;
    logic             mux_load;
    logic             debug;
    logic             aux_uv_flag;
    logic             aux_oc_flag;
    logic [1:0]       safe_cfg;
    logic             safe_ovr;
    logic [1:0]       safe_mode;
    logic             fault;
    logic             int_n;
    logic             rst_req;
    logic             wdog_en;
    logic             io_prot_en;
    logic [7:0]       rdata;
  } sdfc_state_t;
endpackage : sdfc_pkg

// ---- logic/sdfc_ctrl.sv ----
// supply, debug and fail-safe control of a system-basis device
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
module sdfc_ctrl (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       debug_window_i,
  input  wire logic [1:0] safe_resistor_cfg_i,
  input  wire logic       aux_uv_i,
  input  wire logic       aux_oc_i,
  input  wire logic       upper_uv_level_i,
  input  wire logic       lower_uv_level_i,
  input  wire logic       normal_mode_i,
  input  wire logic       low_power_i,
  input  wire logic       fault_event_i,
  output logic [7:0]      rdata_o,
  output logic            bus_supply_en_o,
  output logic            aux_supply_en_o,
  output logic            aux_supply_3v3_o,
  output logic [7:0]      io_mode_o,
  output logic            io_prot_en_o,
  output logic [2:0]      analog_select_out_o,
  output logic            mux_active_o,
  output logic            lin_txrx_en_o,
  output logic            mux_load_en_o,
  output logic            debug_active_o,
  output logic            wdog_en_o,
  output logic            uv_int_n_o,
  output logic            uv_rst_req_o,
  output logic [1:0]      safe_mode_o,
  output logic            safe_n_o,
  output logic            safe_oe_o
);
`include "sdfc_consts.svh"

  sdfc_pkg::sdfc_state_t s_q;
  sdfc_pkg::sdfc_state_t s_d;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off, input logic st);
    hit = st && (a == off);
  endfunction : hit

  always_comb begin
    s_d = s_q;
    s_d.rdata = `SDFC_ZERO8;
    // initial reset phase lasts one cycle after release, then debug window is sampled
    if (s_q.phase == sdfc_pkg::ST_INIT_RESET) begin
      s_d.phase   = sdfc_pkg::ST_RUN;
      s_d.debug   = debug_window_i;
      s_d.bus_en  = debug_window_i;
      s_d.wdog_en = !debug_window_i;
    end else if (s_q.debug && !debug_window_i) begin
      s_d.debug   = 1'b0;
      s_d.wdog_en = 1'b1;
    end
    if (hit(addr_i, `SDFC_OFF_SUPPLY, wr_i)) begin
      s_d.bus_en     = wdata_i[`SDFC_BUS_EN_BIT];
      s_d.aux_en     = wdata_i[`SDFC_AUX_EN_BIT];
      s_d.aux_3v3    = wdata_i[`SDFC_AUX_3V3_BIT];
      s_d.aux_int_en = wdata_i[`SDFC_AUX_INT_BIT];
    end
    if (hit(addr_i, `SDFC_OFF_UV, wr_i)) begin
      s_d.uv_int_sel   = wdata_i[`SDFC_UV_INT_BIT];
      s_d.uv_lower_sel = wdata_i[`SDFC_UV_LOWER_BIT];
    end
    if (hit(addr_i, `SDFC_OFF_IO, wr_i)) begin
      s_d.io_mode = wdata_i;
    end
    if (hit(addr_i, `SDFC_OFF_MUX, wr_i)) begin
      s_d.mux_load = wdata_i[`SDFC_MUX_LOAD_BIT];
      if (s_q.bus_en && wdata_i[2:0] != 3'h7) begin
        s_d.mux_src = sdfc_pkg::sdfc_mux_src_t'(wdata_i[2:0]);
      end
    end
    // exit command wins over debug window still present
    if (hit(addr_i, `SDFC_OFF_DEBUG, wr_i) && wdata_i[`SDFC_DBG_EXIT_BIT]
        && s_q.phase == sdfc_pkg::ST_RUN) begin
      s_d.debug   = 1'b0;
      s_d.wdog_en = 1'b1;
    end
    if (hit(addr_i, `SDFC_OFF_SAFE, wr_i)) begin
      s_d.safe_cfg = wdata_i[1:0];
      s_d.safe_ovr = wdata_i[`SDFC_SAFE_OVR_BIT];
    end
    // status flags: clear by writing one, a new event wins over the clear
    if (hit(addr_i, `SDFC_OFF_STATUS, wr_i)) begin
      if (wdata_i[`SDFC_ST_AUX_UV_BIT]) s_d.aux_uv_flag = 1'b0;
      if (wdata_i[`SDFC_ST_AUX_OC_BIT]) s_d.aux_oc_flag = 1'b0;
      if (wdata_i[`SDFC_ST_FAULT_BIT]) s_d.fault = 1'b0;
    end
    if (aux_uv_i) s_d.aux_uv_flag = 1'b1;
    if (aux_oc_i) s_d.aux_oc_flag = 1'b1;
    if (aux_uv_i || aux_oc_i) begin
      s_d.aux_en = 1'b0;
    end
    if (fault_event_i) s_d.fault = 1'b1;
    // fail-safe selection: command overrides; resistor ignored in debug
    if (s_d.safe_ovr) begin
      s_d.safe_mode = s_d.safe_cfg;
    end else if (!s_d.debug) begin
      s_d.safe_mode = safe_resistor_cfg_i;
    end
    // undervoltage: upper level gives interrupt or reset; lower always resets
    if (s_q.uv_lower_sel && normal_mode_i) begin
      s_d.int_n   = !upper_uv_level_i;
      s_d.rst_req = lower_uv_level_i;
    end else begin
      s_d.int_n   = !(upper_uv_level_i && s_q.uv_int_sel);
      s_d.rst_req = (upper_uv_level_i && !s_q.uv_int_sel) || lower_uv_level_i;
    end
    if (s_q.aux_int_en && (aux_uv_i || aux_oc_i)) begin
      s_d.int_n = 1'b0;
    end
    s_d.io_prot_en = !low_power_i;
    if (rd_i) begin
      unique case (addr_i)
        `SDFC_OFF_SUPPLY: s_d.rdata = {4'h0, s_q.aux_int_en, s_q.aux_3v3, s_q.aux_en, s_q.bus_en};
        `SDFC_OFF_UV:     s_d.rdata = {6'h00, s_q.uv_lower_sel, s_q.uv_int_sel};
        `SDFC_OFF_IO:     s_d.rdata = s_q.io_mode;
        `SDFC_OFF_MUX:    s_d.rdata = {4'h0, s_q.mux_load, s_q.mux_src};
        `SDFC_OFF_DEBUG:  s_d.rdata = {7'h00, s_q.debug};
        `SDFC_OFF_SAFE:   s_d.rdata = {3'h0, s_q.safe_mode, s_q.safe_ovr, s_q.safe_cfg};
        `SDFC_OFF_STATUS: s_d.rdata = {2'h0, s_q.fault, s_q.aux_en, s_q.bus_en,
                                       s_q.aux_oc_flag, s_q.aux_uv_flag, s_q.debug};
        default:          s_d.rdata = `SDFC_ZERO8;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.int_n <= 1'b1;
      s_q.wdog_en <= 1'b1;
      s_q.io_prot_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o             = s_q.rdata;
  assign bus_supply_en_o     = s_q.bus_en;
  assign aux_supply_en_o     = s_q.aux_en;
  assign aux_supply_3v3_o    = s_q.aux_3v3;
  assign io_mode_o           = s_q.io_mode;
  assign io_prot_en_o        = s_q.io_prot_en;
  assign analog_select_out_o = s_q.mux_src;
  assign mux_active_o        = s_q.bus_en;
  assign lin_txrx_en_o       = s_q.bus_en;
  assign mux_load_en_o       = s_q.mux_load;
  assign debug_active_o      = s_q.debug;
  assign wdog_en_o           = s_q.wdog_en;
  assign uv_int_n_o          = s_q.int_n;
  assign uv_rst_req_o        = s_q.rst_req;
  assign safe_mode_o         = s_q.safe_mode;
  assign safe_n_o            = 1'b0;
  assign safe_oe_o           = s_q.fault;

  mux_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_MUX && !bus_supply_en_o)
      |=> $stable(analog_select_out_o))
    else $error("mux source changed while bus rail off");
  aux_trip_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (aux_uv_i || aux_oc_i) |=> !aux_supply_en_o)
    else $error("aux supply not disabled on trip");
  aux_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    aux_uv_i |=> s_q.aux_uv_flag)
    else $error("aux undervoltage flag not set");
  safe_low_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    fault_event_i |=> safe_oe_o && !safe_n_o)
    else $error("fail-safe output not driven low");
  debug_exit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (debug_active_o && !debug_window_i) |=> !debug_active_o && wdog_en_o)
    else $error("debug not left when window lost");
  debug_cmd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_DEBUG && wdata_i[0] && s_q.phase == sdfc_pkg::ST_RUN)
      |=> !debug_active_o)
    else $error("debug exit command ignored");
  debug_wdog_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    debug_active_o |-> !wdog_en_o)
    else $error("watchdog running in debug");
  safe_cmd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_q.safe_ovr |-> safe_mode_o == s_q.safe_cfg)
    else $error("command fail-safe config not applied");
  uv_lower_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.uv_lower_sel && normal_mode_i && upper_uv_level_i && !lower_uv_level_i)
      |=> !uv_int_n_o && !uv_rst_req_o)
    else $error("upper level crossing misreported");
  prot_lp_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    low_power_i |=> !io_prot_en_o)
    else $error("io protection on in low power");

  // bus rail: moves only on a host write or on leaving the initial reset phase
  bus_on_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_SUPPLY && wdata_i[`SDFC_BUS_EN_BIT])
      |=> bus_supply_en_o)
    else $error("bus rail write not applied");

  bus_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_SUPPLY && !wdata_i[`SDFC_BUS_EN_BIT])
      |=> !bus_supply_en_o)
    else $error("bus rail not switched off");

  bus_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!bus_supply_en_o && s_q.phase == sdfc_pkg::ST_RUN && !(wr_i && addr_i == `SDFC_OFF_SUPPLY))
      |=> !bus_supply_en_o)
    else $error("bus rail came on without a write");

  dbg_rail_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.phase == sdfc_pkg::ST_INIT_RESET && debug_window_i && !(wr_i && addr_i == `SDFC_OFF_SUPPLY))
      |=> bus_supply_en_o)
    else $error("bus rail not on by default in debug");

  // aux supply: host switch, level choice and trip handling
  aux_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!aux_supply_en_o && !(wr_i && addr_i == `SDFC_OFF_SUPPLY))
      |=> !aux_supply_en_o)
    else $error("aux supply came on without a write");

  aux_on_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_SUPPLY && wdata_i[`SDFC_AUX_EN_BIT] && !aux_uv_i && !aux_oc_i)
      |=> aux_supply_en_o)
    else $error("aux supply write not applied");

  aux_3v3_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_SUPPLY && wdata_i[`SDFC_AUX_3V3_BIT])
      |=> aux_supply_3v3_o)
    else $error("aux low level not selected");

  aux_5v0_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_SUPPLY && !wdata_i[`SDFC_AUX_3V3_BIT])
      |=> !aux_supply_3v3_o)
    else $error("aux high level not selected");

  aux_oc_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    aux_oc_i |=> s_q.aux_oc_flag)
    else $error("aux overcurrent flag not set");

  aux_int_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.aux_int_en && (aux_uv_i || aux_oc_i))
      |=> !uv_int_n_o)
    else $error("aux trip interrupt missing");

  aux_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.aux_uv_flag && !(wr_i && addr_i == `SDFC_OFF_STATUS))
      |=> s_q.aux_uv_flag)
    else $error("aux undervoltage flag lost");

  aux_clr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_STATUS && wdata_i[`SDFC_ST_AUX_UV_BIT] && !aux_uv_i)
      |=> !s_q.aux_uv_flag)
    else $error("aux undervoltage flag not cleared");

  // main supply undervoltage reporting
  uv_reset_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!s_q.uv_lower_sel && !s_q.uv_int_sel && upper_uv_level_i)
      |=> uv_rst_req_o)
    else $error("upper level did not request reset");

  uv_intr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!s_q.uv_lower_sel && s_q.uv_int_sel && upper_uv_level_i && !lower_uv_level_i)
      |=> !uv_int_n_o && !uv_rst_req_o)
    else $error("upper level did not interrupt");

  uv_deep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.uv_lower_sel && normal_mode_i && lower_uv_level_i)
      |=> uv_rst_req_o)
    else $error("lower level did not request reset");

  // io pins and their protection
  io_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_IO)
      |=> io_mode_o == $past(wdata_i))
    else $error("io mode write not applied");

  io_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(wr_i && addr_i == `SDFC_OFF_IO)
      |=> $stable(io_mode_o))
    else $error("io mode changed without a write");

  prot_on_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !low_power_i |=> io_prot_en_o)
    else $error("io protection off outside low power");

  // analog mux selection and load
  mux_code_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    analog_select_out_o != 3'h7)
    else $error("unused mux code selected");

  mux_take_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_MUX && bus_supply_en_o && wdata_i[2:0] != 3'h7)
      |=> {5'h00, analog_select_out_o} == ($past(wdata_i) & 8'h07))
    else $error("mux source write not applied");

  mux_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(wr_i && addr_i == `SDFC_OFF_MUX)
      |=> $stable(analog_select_out_o))
    else $error("mux source changed without a write");

  load_on_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_MUX && wdata_i[`SDFC_MUX_LOAD_BIT])
      |=> mux_load_en_o)
    else $error("load resistor not connected");

  load_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == `SDFC_OFF_MUX && !wdata_i[`SDFC_MUX_LOAD_BIT])
      |=> !mux_load_en_o)
    else $error("load resistor not released");

  // debug entry, flag and watchdog
  dbg_enter_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_q.phase == sdfc_pkg::ST_INIT_RESET)
      |=> debug_active_o == $past(debug_window_i))
    else $error("debug window not sampled at entry");

  dbg_late_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!debug_active_o && s_q.phase == sdfc_pkg::ST_RUN)
      |=> !debug_active_o)
    else $error("debug entered after initial phase");

  dbg_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == `SDFC_OFF_STATUS)
      |=> rdata_o[`SDFC_ST_DBG_BIT] == $past(debug_active_o))
    else $error("debug flag misreported");

  wdog_run_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!debug_active_o && s_q.phase == sdfc_pkg::ST_RUN)
      |-> wdog_en_o)
    else $error("watchdog idle outside debug");

  // fail-safe configuration and output
  safe_res_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    1'b1
      |=> s_q.safe_ovr || debug_active_o || safe_mode_o == $past(safe_resistor_cfg_i))
    else $error("resistor fail-safe config not tracked");

  safe_dbg_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (debug_active_o && !s_q.safe_ovr)
      |=> s_q.safe_ovr || !debug_active_o || $stable(safe_mode_o))
    else $error("resistor changed fail-safe config in debug");

  fault_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (safe_oe_o && !(wr_i && addr_i == `SDFC_OFF_STATUS))
      |=> safe_oe_o)
    else $error("fail-safe output released without clear");
endmodule : sdfc_ctrl

// ---- tb/sdfc_host_model.sv ----
// host microcontroller model driving the register port of the control block
module sdfc_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [3:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // rail capacitor charge time in clocks, a plain default
  parameter int SETTLE_CYC = 4;

  initial begin
    addr_o  = 4'h0;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    wr_o    <= 1'b0;
    #1;
  endtask : write_reg

  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    rd_o   <= 1'b0;
    #1;
    d = rdata_i;
  endtask : read_reg

  // source select only after the bus rail had time to charge
  task automatic wait_settle();
    repeat (SETTLE_CYC) @(posedge sys_clk_i);
  endtask : wait_settle
endmodule : sdfc_host_model

// ---- tb/testbench.sv ----
// self-checking bench for the supply, debug and fail-safe control block
`include "sdfc_consts.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_n = 1'b0, dbg_win = 1'b0, aux_uv = 1'b0, aux_oc = 1'b0;
  logic       up_uv = 1'b0, lo_uv = 1'b0, normal = 1'b1, low_pwr = 1'b0, fault = 1'b0;
  logic [1:0] res_cfg = 2'h1;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic       wr, rd, bus_en, aux_en, aux_3v3, prot, mux_act, lin_en, load, dbg, wdog;
  logic       int_n, rst_req, safe_n, safe_oe;
  logic [7:0] io_mode;
  logic [2:0] src;
  logic [1:0] safe_mode;
  int         mismatches = 0, n_checks = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  sdfc_host_model host (.sys_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));

  sdfc_ctrl DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .debug_window_i(dbg_win), .safe_resistor_cfg_i(res_cfg), .aux_uv_i(aux_uv),
    .aux_oc_i(aux_oc), .upper_uv_level_i(up_uv), .lower_uv_level_i(lo_uv),
    .normal_mode_i(normal), .low_power_i(low_pwr), .fault_event_i(fault), .rdata_o(rdata),
    .bus_supply_en_o(bus_en), .aux_supply_en_o(aux_en), .aux_supply_3v3_o(aux_3v3),
    .io_mode_o(io_mode), .io_prot_en_o(prot), .analog_select_out_o(src),
    .mux_active_o(mux_act), .lin_txrx_en_o(lin_en), .mux_load_en_o(load),
    .debug_active_o(dbg), .wdog_en_o(wdog), .uv_int_n_o(int_n), .uv_rst_req_o(rst_req),
    .safe_mode_o(safe_mode), .safe_n_o(safe_n), .safe_oe_o(safe_oe));

  // pin level decides debug entry, so it is set before release
  task automatic do_reset(input logic win);
    dbg_win <= win;
    rst_n   <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n   <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : do_reset

  task automatic t_defaults();
    do_reset(1'b0);
    `CHK(bus_en, 1'b0)
    `CHK(aux_en, 1'b0)
    `CHK(io_mode, 8'h00)
    `CHK(dbg, 1'b0)
    `CHK(wdog, 1'b1)
    `CHK(safe_mode, res_cfg)
    host.write_reg(`SDFC_OFF_IO, 8'he4);
    `CHK(io_mode, 8'he4)
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_mux();
    host.write_reg(`SDFC_OFF_MUX, 8'h05);
    `CHK(src, 3'h0)
    `CHK(mux_act, 1'b0)
    host.write_reg(`SDFC_OFF_SUPPLY, 8'h01);
    `CHK(bus_en, 1'b1)
    `CHK(lin_en, 1'b1)
    host.wait_settle();
    host.write_reg(`SDFC_OFF_MUX, 8'h0d);
    `CHK(src, 3'(sdfc_pkg::MUX_DIE_TEMP))
    `CHK(load, 1'b1)
    $display("test mux done");
  endtask : t_mux

  task automatic t_aux();
    host.write_reg(`SDFC_OFF_SUPPLY, 8'h0f);
    `CHK(aux_en, 1'b1)
    `CHK(aux_3v3, 1'b1)
    aux_uv <= 1'b1;
    repeat (2) @(posedge clk);
    aux_uv <= 1'b0;
    #1;
    `CHK(aux_en, 1'b0)
    `CHK(int_n, 1'b0)
    host.read_reg(`SDFC_OFF_STATUS, d);
    `CHK(d[`SDFC_ST_AUX_UV_BIT], 1'b1)
    host.write_reg(`SDFC_OFF_SUPPLY, 8'h03);
    aux_oc <= 1'b1;
    @(posedge clk);
    aux_oc <= 1'b0;
    host.read_reg(`SDFC_OFF_STATUS, d);
    `CHK(d[`SDFC_ST_AUX_OC_BIT], 1'b1)
    `CHK(aux_en, 1'b0)
    $display("test aux done");
  endtask : t_aux

  task automatic t_uv();
    host.write_reg(`SDFC_OFF_UV, 8'h00);
    up_uv <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(rst_req, 1'b1)
    host.write_reg(`SDFC_OFF_UV, 8'h01);
    @(posedge clk);
    #1;
    `CHK({int_n, rst_req}, 2'b00)
    host.write_reg(`SDFC_OFF_UV, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    `CHK({int_n, rst_req}, 2'b00)
    lo_uv <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(rst_req, 1'b1)
    up_uv <= 1'b0;
    lo_uv <= 1'b0;
    $display("test undervoltage done");
  endtask : t_uv

  task automatic t_debug();
    do_reset(1'b1);
    `CHK(dbg, 1'b1)
    `CHK(bus_en, 1'b1)
    `CHK(wdog, 1'b0)
    res_cfg <= 2'h2;
    host.read_reg(`SDFC_OFF_STATUS, d);
    `CHK(d[`SDFC_ST_DBG_BIT], 1'b1)
    `CHK(safe_mode, 2'h0)
    host.write_reg(`SDFC_OFF_DEBUG, 8'h01);
    `CHK(dbg, 1'b0)
    do_reset(1'b1);
    dbg_win <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK({dbg, wdog}, 2'b01)
    host.write_reg(`SDFC_OFF_SAFE, 8'h07);
    `CHK(safe_mode, 2'h3)
    $display("test debug done");
  endtask : t_debug

  task automatic t_safe();
    low_pwr <= 1'b1;
    fault   <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(prot, 1'b0)
    `CHK({safe_oe, safe_n}, 2'b10)
    $display("test fail-safe done");
  endtask : t_safe

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    t_defaults();
    t_mux();
    t_aux();
    t_uv();
    t_debug();
    t_safe();
    conclude();
  end
endmodule : testbench
